// ---- rtl/tmr_pkg.sv ----
package tmr_pkg;
	// Oscillator periods per machine cycle and per state time
	localparam int OSC_PER_MCYCLE = 12;
	localparam int OSC_PER_STATE  = 2;
	localparam logic [3:0] MCYC_LAST  = 4'hb;
	localparam logic [3:0] STATE_LAST = 4'h1;
	// Phase at which the overflow flag lands (state 2 phase 2)
	localparam logic [3:0] PHASE_STATE_TWO_PHASE_TWO = 4'h3;
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [15:0] CNT_MAX   = 16'hffff;
	// Baud divider: serial rate is overflow rate over 16
	localparam logic [3:0] BAUD_DIV_LAST = 4'hf;

	// Control register fields
	typedef struct packed {
		logic ovf_flag;
		logic ext_flag;
		logic rx_clock_select;
		logic tx_clock_select;
		logic ext_trigger_enable;
		logic run_control;
		logic counter_timer_select;
		logic capture_not_reload;
	} tmr_ctrl_type;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// Register offsets on the plain port
	localparam logic [2:0] ADDR_CTRL   = 3'h0;
	localparam logic [2:0] ADDR_MODE   = 3'h1;
	localparam logic [2:0] ADDR_CNT_LO = 3'h2;
	localparam logic [2:0] ADDR_CNT_HI = 3'h3;
	localparam logic [2:0] ADDR_CAP_LO = 3'h4;
	localparam logic [2:0] ADDR_CAP_HI = 3'h5;
	localparam int         MODE_OE_BIT = 1;

	// Register port request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [2:0] addr;
		logic [7:0] wdata;
	} tmr_bus_type;
endpackage

// ---- rtl/tmr_timer2.sv ----
`timescale 1ns/1ns
`default_nettype none
// Function
// [RQ1] Capture mode, trigger disabled: 16-bit timer/counter, overflow sets overflow flag.
// [RQ2] Capture mode, trigger enabled: trigger falling edge copies count into capture registers.
// [RQ3] Qualifying trigger falling edge also sets the external event flag.
// [RQ4] Interrupt request is OR of overflow flag and external event flag.
// [RQ5] Flags are cleared only by software, never on service.
// [RQ6] Either tx or rx clock select bit enables baud generator mode.
// [RQ7] Baud mode: high byte rollover reloads count from capture/reload registers.
// [RQ8] Serial baud tick is timer overflow rate divided by 16.
// [RQ9] Timer counts per machine cycle; baud generator counts per state time.
// [RQ10] Baud rate is osc over 32 times (65536 minus reload).
// [RQ11] Baud mode rollover sets no overflow flag and no interrupt.
// [RQ12] Baud mode trigger edge sets event flag, never reloads.
// [RQ13] Software stops the timer before touching count or reload registers.
// [RQ14] Software clears counter select and sets clock out enable for clock-out.
// [RQ15] Clock-out drives 50% square wave on shared count pin.
// [RQ16] Clock-out frequency is osc over 4 times (65536 minus reload).
// [RQ17] Clock-out rollovers raise no interrupt.
// [RQ18] Baud generation and clock-out run together from one reload value.
// [RQ19] Overflow flag set at state two phase two of overflow cycle.
// [RQ20] Counter select 0 counts internal clock, 1 counts external pulses. In baud mode the code counts state times whatever the select.
// [RQ21] Shared pin also serves as external count input.
// [RQ22] External falling edge recognised after two machine cycles of samples.
// [RQ23] Trigger and count pins synchronised; edges found by per-cycle samples.
module tmr_timer2
	import tmr_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire tmr_bus_type bus,
	output logic [7:0]       rdata,
	input  wire logic        trigger_input,
	input  wire logic        count_pin_in,
	output logic             count_pin_out,
	output logic             count_pin_oe,
	output logic             timer_irq,
	output logic             baud_tick
);

	tmr_ctrl_type ctrl_q;
	logic         clock_out_enable_q;
	logic [15:0]  count_q;
	logic [15:0]  reload_q;
	logic [3:0]   phase_q;
	logic [2:0]   trig_sync_q;
	logic [2:0]   cnt_sync_q;
	logic         trig_lvl_q;
	logic         cnt_lvl_q;
	logic         trig_smp_q;
	logic         cnt_smp_q;
	logic         clk_out_q;
	logic [3:0]   baud_div_q;
	logic [7:0]   rdata_q;
	logic         mcycle_tick;
	logic         state_tick;
	logic         baud_mode;
	logic         clkout_mode;
	logic         trig_fall;
	logic         cnt_fall;
	logic         inc_en;
	logic         rollover;
	logic         ovf_set;
	logic         ext_set;

	// Oscillator phase within one machine cycle
	always_ff @(posedge clk) begin
		if (sys_rst || phase_q == MCYC_LAST)
			phase_q <= 4'h0;
		else
			phase_q <= phase_q + 4'h1;
	end

	// Overflow lands at state two phase two so the interrupt logic sees it that cycle
	assign mcycle_tick = (phase_q == PHASE_STATE_TWO_PHASE_TWO);              // RQ19
	assign state_tick  = phase_q[0] == STATE_LAST[0];          // RQ9

	// Three-stage synchronisers; change counts when stages two and three agree
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			trig_sync_q <= 3'h7;
			cnt_sync_q  <= 3'h7;
			trig_lvl_q  <= 1'b1;
			cnt_lvl_q   <= 1'b1;
		end else begin
			trig_sync_q <= {trig_sync_q[1:0], trigger_input};
			cnt_sync_q  <= {cnt_sync_q[1:0], count_pin_in};
			if (trig_sync_q[2] == trig_sync_q[1])
				trig_lvl_q <= trig_sync_q[2];             // RQ23
			if (cnt_sync_q[2] == cnt_sync_q[1])
				cnt_lvl_q <= cnt_sync_q[2];               // RQ23
		end
	end

	// Samples taken once per machine cycle; edge is seen one cycle after the high sample
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			trig_smp_q <= 1'b1;
			cnt_smp_q  <= 1'b1;
		end else if (mcycle_tick) begin
			trig_smp_q <= trig_lvl_q;
			cnt_smp_q  <= cnt_lvl_q;
		end
	end
	assign trig_fall = mcycle_tick && trig_smp_q && !trig_lvl_q;             // RQ23
	assign cnt_fall  = mcycle_tick && cnt_smp_q && !cnt_lvl_q;               // RQ22

	assign baud_mode   = ctrl_q.tx_clock_select || ctrl_q.rx_clock_select;   // RQ6
	assign clkout_mode = clock_out_enable_q && !ctrl_q.counter_timer_select;

	// Count source: baud and clock-out run per state time, else machine cycle or pin
	always_comb begin
		if (!ctrl_q.run_control)
			inc_en = 1'b0;
		else if (baud_mode || clkout_mode)
			inc_en = state_tick;                                            // RQ9 RQ18
		else if (ctrl_q.counter_timer_select)
			inc_en = cnt_fall;                                              // RQ20 RQ21
		else
			inc_en = mcycle_tick;                                           // RQ9 RQ20
	end
	assign rollover = inc_en && (count_q == CNT_MAX);

	// Plain timer overflow only; baud and clock-out rollovers stay silent
	assign ovf_set = rollover && !baud_mode && !clkout_mode;                // RQ1 RQ11 RQ17
	assign ext_set = trig_fall && ctrl_q.ext_trigger_enable;                // RQ3 RQ12

	// Count register; reload on rollover in baud, clock-out or auto-reload mode
	always_ff @(posedge clk) begin
		if (sys_rst)
			count_q <= CNT_RESET;
		else if (bus.wr && bus.addr == ADDR_CNT_LO)
			count_q[7:0] <= bus.wdata;                                      // RQ13
		else if (bus.wr && bus.addr == ADDR_CNT_HI)
			count_q[15:8] <= bus.wdata;
		else if (rollover && (baud_mode || clkout_mode || !ctrl_q.capture_not_reload))
			count_q <= reload_q;                                            // RQ7 RQ10 RQ16
		else if (ext_set && !baud_mode && !ctrl_q.capture_not_reload)
			count_q <= reload_q;
		else if (inc_en)
			count_q <= count_q + 16'h0001;                                  // RQ1
	end

	// Capture registers; a trigger edge in baud mode never captures
	always_ff @(posedge clk) begin
		if (sys_rst)
			reload_q <= CNT_RESET;
		else if (ext_set && !baud_mode && ctrl_q.capture_not_reload)
			reload_q <= count_q;                                            // RQ2
		else if (bus.wr && bus.addr == ADDR_CAP_LO)
			reload_q[7:0] <= bus.wdata;
		else if (bus.wr && bus.addr == ADDR_CAP_HI)
			reload_q[15:8] <= bus.wdata;
	end

	// Control register; hardware set wins over a software clear in the same cycle
	always_ff @(posedge clk) begin
		if (sys_rst)
			ctrl_q <= tmr_ctrl_type'(CTRL_RESET);
		else begin
			if (bus.wr && bus.addr == ADDR_CTRL)
				ctrl_q <= tmr_ctrl_type'(bus.wdata);
			if (ovf_set)
				ctrl_q.ovf_flag <= 1'b1;                                    // RQ5 RQ19
			if (ext_set)
				ctrl_q.ext_flag <= 1'b1;                                    // RQ5 RQ3
		end
	end

	// Mode register holds only the clock-out enable
	always_ff @(posedge clk) begin
		if (sys_rst)
			clock_out_enable_q <= 1'b0;
		else if (bus.wr && bus.addr == ADDR_MODE)
			clock_out_enable_q <= bus.wdata[MODE_OE_BIT];                   // RQ14
	end

	// Clock-out toggles on each rollover for a 50% duty square wave
	always_ff @(posedge clk) begin
		if (sys_rst || !clkout_mode)
			clk_out_q <= 1'b0;
		else if (rollover)
			clk_out_q <= !clk_out_q;                                        // RQ15 RQ16
	end
	assign count_pin_out = clk_out_q;
	assign count_pin_oe  = clkout_mode;                                     // RQ15

	// Divide rollovers by 16 for the serial port bit tick
	always_ff @(posedge clk) begin
		if (sys_rst || !baud_mode)
			baud_div_q <= 4'h0;
		else if (rollover)
			baud_div_q <= baud_div_q + 4'h1;                                // RQ8
	end
	assign baud_tick = baud_mode && rollover && (baud_div_q == BAUD_DIV_LAST); // RQ8 RQ10

	assign timer_irq = ctrl_q.ovf_flag || ctrl_q.ext_flag;                  // RQ4

	// Read data one cycle after the strobe, zero otherwise
	always_ff @(posedge clk) begin
		if (sys_rst || !bus.rd)
			rdata_q <= 8'h00;
		else begin
			case (bus.addr)
				ADDR_CTRL:   rdata_q <= ctrl_q;
				ADDR_MODE:   rdata_q <= {6'h00, clock_out_enable_q, 1'b0};
				ADDR_CNT_LO: rdata_q <= count_q[7:0];
				ADDR_CNT_HI: rdata_q <= count_q[15:8];
				ADDR_CAP_LO: rdata_q <= reload_q[7:0];
				ADDR_CAP_HI: rdata_q <= reload_q[15:8];
				default:     rdata_q <= 8'h00;
			endcase
		end
	end
	assign rdata = rdata_q;

	// Interrupt request follows the two flags in the same cycle
	AST_IRQ_OR: assert property (@(posedge clk) disable iff (sys_rst) // RQ4
		timer_irq == (ctrl_q.ovf_flag || ctrl_q.ext_flag))
		else $error("irq not OR of flags");

	// Request only rises from a hardware set or a software write of the flags
	AST_IRQ_RISE: assert property (@(posedge clk) disable iff (sys_rst) // RQ4
		$rose(timer_irq)
		|-> $past(ovf_set || ext_set) || $past(bus.wr && bus.addr == ADDR_CTRL))
		else $error("irq rose without cause");

	// A plain timer overflow always lands in the flag
	AST_OVF_SET: assert property (@(posedge clk) disable iff (sys_rst) // RQ1
		ovf_set
		|=> ctrl_q.ovf_flag)
		else $error("overflow flag not set");

	// The overflow flag never appears on its own
	AST_OVF_CAUSE: assert property (@(posedge clk) disable iff (sys_rst) // RQ1
		$rose(ctrl_q.ovf_flag)
		|-> $past(ovf_set) || $past(bus.wr && bus.addr == ADDR_CTRL))
		else $error("overflow flag set without overflow");

	// Overflow is only flagged on the state two phase two tick
	AST_OVF_PHASE: assert property (@(posedge clk) disable iff (sys_rst) // RQ19
		ovf_set
		|-> mcycle_tick)
		else $error("overflow flagged off phase");

	// Only a software write may clear the overflow flag
	AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (sys_rst) // RQ5
		ctrl_q.ovf_flag && !(bus.wr && bus.addr == ADDR_CTRL)
		|=> ctrl_q.ovf_flag)
		else $error("overflow flag dropped");

	// Only a software write may clear the event flag
	AST_EXT_STICKY: assert property (@(posedge clk) disable iff (sys_rst) // RQ5
		ctrl_q.ext_flag && !(bus.wr && bus.addr == ADDR_CTRL)
		|=> ctrl_q.ext_flag)
		else $error("event flag dropped");

	// Baud rollovers stay silent
	AST_BAUD_NO_OVF: assert property (@(posedge clk) disable iff (sys_rst) // RQ11
		baud_mode && rollover
		|-> !ovf_set)
		else $error("baud rollover set flag");

	// Baud rollover reloads the whole count from the reload registers
	AST_BAUD_RELOAD: assert property (@(posedge clk) disable iff (sys_rst) // RQ7
		baud_mode && rollover && !bus.wr
		|=> count_q == $past(reload_q))
		else $error("no reload");

	// Baud mode advances once per state time
	AST_BAUD_STEP: assert property (@(posedge clk) disable iff (sys_rst) // RQ9
		baud_mode && ctrl_q.run_control && state_tick && !rollover && !bus.wr
		|=> count_q == $past(count_q) + 16'h0001)
		else $error("baud count did not step");

	// Plain timer advances only on the machine-cycle tick
	AST_TIMER_STEP: assert property (@(posedge clk) disable iff (sys_rst) // RQ20
		ctrl_q.run_control && !ctrl_q.counter_timer_select && !baud_mode && !clkout_mode
		&& !rollover && !ext_set && !bus.wr
		|=> count_q == $past(count_q) + {15'h0000, $past(mcycle_tick)})
		else $error("timer count off rate");

	// Counter advances only on a recognised pin fall
	AST_COUNTER_STEP: assert property (@(posedge clk) disable iff (sys_rst) // RQ22
		ctrl_q.run_control && ctrl_q.counter_timer_select && !baud_mode
		&& !rollover && !ext_set && !bus.wr
		|=> count_q == $past(count_q) + {15'h0000, $past(cnt_fall)})
		else $error("counter off pin edges");

	// No second recognised fall within eight clocks of the first
	AST_FALL_SPACING: assert property (@(posedge clk) disable iff (sys_rst) // RQ22
		cnt_fall
		|=> !cnt_fall [*8])
		else $error("pin falls too close");

	// Trigger edge in capture mode copies the count
	AST_CAPTURE: assert property (@(posedge clk) disable iff (sys_rst) // RQ2
		ext_set && !baud_mode && ctrl_q.capture_not_reload
		|=> reload_q == $past(count_q))
		else $error("capture missed");

	// Reload registers move only on capture or software write
	AST_CAPTURE_CAUSE: assert property (@(posedge clk) disable iff (sys_rst) // RQ2
		!$stable(reload_q)
		|-> $past(ext_set && !baud_mode && ctrl_q.capture_not_reload)
		|| $past(bus.wr && (bus.addr == ADDR_CAP_LO || bus.addr == ADDR_CAP_HI)))
		else $error("reload registers changed without cause");

	// Qualifying trigger edge sets the event flag
	AST_EXT_FLAG: assert property (@(posedge clk) disable iff (sys_rst) // RQ3
		ext_set
		|=> ctrl_q.ext_flag)
		else $error("event flag not set");

	// Event flag never appears on its own
	AST_EXT_CAUSE: assert property (@(posedge clk) disable iff (sys_rst) // RQ3
		$rose(ctrl_q.ext_flag)
		|-> $past(ext_set) || $past(bus.wr && bus.addr == ADDR_CTRL))
		else $error("event flag set without edge");

	// Baud mode trigger edge neither reloads nor captures
	AST_BAUD_EXT_NO_LOAD: assert property (@(posedge clk) disable iff (sys_rst) // RQ12
		baud_mode && ext_set && !rollover && !bus.wr
		|=> count_q == $past(count_q) + {15'h0000, $past(inc_en)} && reload_q == $past(reload_q))
		else $error("baud trigger moved count");

	// Clock-out rollovers stay silent
	AST_CLKOUT_NO_OVF: assert property (@(posedge clk) disable iff (sys_rst) // RQ17
		clkout_mode && rollover
		|-> !ovf_set)
		else $error("clock-out rollover set flag");

	// Clock-out pin flips on each rollover
	AST_CLKOUT_TOGGLE: assert property (@(posedge clk) disable iff (sys_rst) // RQ15
		clkout_mode && rollover && !bus.wr
		|=> count_pin_out != $past(count_pin_out))
		else $error("clock-out missed toggle");

	// Clock-out pin holds between rollovers, which keeps the duty at half
	AST_CLKOUT_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // RQ16
		clkout_mode && !rollover && !bus.wr
		|=> count_pin_out == $past(count_pin_out))
		else $error("clock-out changed between rollovers");

	// Divider steps once per baud rollover
	AST_BAUD_DIV: assert property (@(posedge clk) disable iff (sys_rst) // RQ8
		baud_mode && rollover && !bus.wr
		|=> baud_div_q == $past(baud_div_q) + 4'h1)
		else $error("baud divider off");

	// Trigger level only moves once two synchroniser stages agree
	AST_SYNC_AGREE: assert property (@(posedge clk) disable iff (sys_rst) // RQ23
		!$stable(trig_lvl_q)
		|-> $past(trig_sync_q[2] == trig_sync_q[1]))
		else $error("trigger level moved on disagreement");

	// State tick every second oscillator period
	AST_STATE_RATE: assert property (@(posedge clk) disable iff (sys_rst) // RQ9
		state_tick
		|=> !state_tick ##1 state_tick)
		else $error("state tick not every 2");

	// Main scenarios reached
	COV_OVF: cover property (@(posedge clk) disable iff (sys_rst) ovf_set);
	COV_CAPTURE: cover property (@(posedge clk) disable iff (sys_rst)
		ext_set && ctrl_q.capture_not_reload);
	COV_BAUD: cover property (@(posedge clk) disable iff (sys_rst) baud_tick);
	COV_CLKOUT: cover property (@(posedge clk) disable iff (sys_rst) clkout_mode && rollover);
	COV_COUNT: cover property (@(posedge clk) disable iff (sys_rst)
		cnt_fall && ctrl_q.run_control && ctrl_q.counter_timer_select);

endmodule // tmr_timer2
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import tmr_pkg::*;
	logic        clk        = 1'h0;
	logic        sys_rst    = 1'h1;
	tmr_bus_type bus        = '0;
	logic        trig       = 1'h1;
	logic        cpin       = 1'h1;
	logic [31:0] seed       = 32'h26;
	logic [7:0]  rdata, d, c;
	logic [15:0] r;
	logic        cout, coe, irq, btick;
	wire logic   pin_lvl;
	int          errors     = 0;
	int          num_checks = 0;
	int          cyc        = 0;
	int          t0, t1, k, np;

	// Shared pin level: the block wins while it drives, else the bench
	assign pin_lvl = coe ? cout : cpin;

	tmr_timer2 DUT (.clk(clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata), .trigger_input(trig),
		.count_pin_in(pin_lvl), .count_pin_out(cout), .count_pin_oe(coe), .timer_irq(irq), .baud_tick(btick));

	// Clock and hang guard; longest test path stays well below the ceiling
	always #2 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			final_report();
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// Expected spacings in clocks: two clocks per state time
	function automatic int baud_per(input logic [15:0] rl);
		return 32 * (65536 - int'(rl));
	endfunction
	function automatic int half_per(input logic [15:0] rl);
		return 2 * (65536 - int'(rl));
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk);
		bus <= '{1'h1, 1'h0, a, v};
		@(posedge clk);
		bus <= '0;
	endtask
	// Read data are only valid in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge clk);
		bus <= '{1'h0, 1'h1, a, 8'h00};
		@(posedge clk);
		bus <= '0;
		#1 v = rdata;
	endtask
	task automatic rchk(input logic [2:0] a, input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		check(v, e);
	endtask
	// Pulse and pin watchers sample at the falling edge, away from updates
	task automatic next_tick(output int t);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (btick !== 1'h1 && n < 3000);
		t = cyc;
	endtask
	task automatic next_tog(output int t);
		int n;
		logic p;
		n = 0;
		p = cout;
		do begin
			@(negedge clk);
			n++;
		end while (cout === p && n < 3000);
		t = cyc;
	endtask
	task automatic final_report;
		if (errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge clk);
		sys_rst <= 1'h0;
		// Reset values, address 6 is unmapped
		for (k = 0; k < 7; k++) rchk(k[2:0], 8'h00);
		check(irq, 1'h0);
		check(coe, 1'h0);
		// Random reload values read back while stopped
		repeat (4) begin
			seed = xs(seed);
			wr(ADDR_CAP_LO, seed[7:0]);
			wr(ADDR_CAP_HI, seed[15:8]);
			rchk(ADDR_CAP_LO, seed[7:0]);
			rchk(ADDR_CAP_HI, seed[15:8]);
		end
		// Timer: two machine cycles from ffff-1 to overflow
		wr(ADDR_CNT_LO, 8'hfe);
		wr(ADDR_CNT_HI, 8'hff);
		wr(ADDR_CTRL, 8'h05);
		@(posedge clk) trig <= 1'h0;
		cycles(8);
		check(irq, 1'h0);
		cycles(40);
		check(irq, 1'h1);
		rchk(ADDR_CTRL, 8'h85);
		wr(ADDR_CTRL, 8'h05);
		cycles(1);
		check(irq, 1'h0);
		// Capture with trigger enabled on a running count
		wr(ADDR_CTRL, 8'h01);
		@(posedge clk) trig <= 1'h1;
		wr(ADDR_CNT_LO, 8'h34);
		wr(ADDR_CNT_HI, 8'h12);
		cycles(30);
		wr(ADDR_CTRL, 8'h0d);
		@(posedge clk) trig <= 1'h0;
		cycles(40);
		check(irq, 1'h1);
		rchk(ADDR_CAP_HI, 8'h12);
		rd(ADDR_CAP_LO, d);
		check(d >= 8'h34 && d <= 8'h3a, 1'h1);
		rchk(ADDR_CTRL, 8'h4d);
		wr(ADDR_CTRL, 8'h00);
		@(posedge clk) trig <= 1'h1;
		// Counter: a random number of slow external pulses
		wr(ADDR_CNT_LO, 8'h00);
		wr(ADDR_CNT_HI, 8'h00);
		wr(ADDR_CTRL, 8'h07);
		seed = xs(seed);
		np = int'(seed[2:0]) + 1;
		repeat (np) begin
			@(posedge clk) cpin <= 1'h0;
			repeat (24) @(posedge clk);
			cpin <= 1'h1;
			repeat (24) @(posedge clk);
		end
		cycles(30);
		wr(ADDR_CTRL, 8'h01);
		rchk(ADDR_CNT_LO, 8'(np));
		// Baud and clock-out together, once per clock select bit
		for (k = 0; k < 2; k++) begin
			wr(ADDR_CTRL, 8'h00);
			seed = xs(seed);
			r = 16'hfff8 + 16'(seed[2:0]);
			c = k ? 8'h2c : 8'h1c;
			wr(ADDR_CAP_LO, r[7:0]);
			wr(ADDR_CAP_HI, r[15:8]);
			wr(ADDR_CNT_LO, r[7:0]);
			wr(ADDR_CNT_HI, r[15:8]);
			wr(ADDR_MODE, 8'h02);
			wr(ADDR_CTRL, c);
			cycles(1);
			check(coe, 1'h1);
			next_tick(t0);
			next_tick(t1);
			check(16'(t1 - t0), 16'(baud_per(r)));
			next_tog(t0);
			next_tog(t1);
			check(16'(t1 - t0), 16'(half_per(r)));
			next_tog(t0);
			check(16'(t0 - t1), 16'(half_per(r)));
			@(posedge clk) trig <= 1'h0;
			cycles(40);
			rchk(ADDR_CTRL, c | 8'h40);
			@(posedge clk) trig <= 1'h1;
			cycles(30);
		end
		wr(ADDR_MODE, 8'h00);
		cycles(2);
		check(coe, 1'h0);
		final_report();
	end
endmodule // testbench
`default_nettype wire
